/* File: design/cti_pkg.sv */
// Package for the computer telemetry interface: counter limits, timing constants, states.
// Assumes a 100 MHz core clock; sync inputs arrive asynchronously from the encoder.
package cti_pkg;
   localparam int unsigned CORE_CLK_MHZ     = 100;
   localparam logic [4:0]  SLOT_MAX         = 5'h1e;
   localparam logic [3:0]  FRAME_MAX        = 4'ha;
   localparam logic [1:0]  SHARED_MAX       = 2'h3;
   localparam logic [4:0]  SLOT_RST_VAL     = 5'h01;
   localparam logic [3:0]  FRAME_RST_VAL    = 4'h1;
   localparam logic [1:0]  SHARED_RST_VAL   = 2'h1;
   localparam int unsigned CLR_TO_LOAD_US   = 3;
   localparam int unsigned READY_WIDTH_US   = 4;
   localparam int unsigned CLR_TO_LOAD_CYC  = CLR_TO_LOAD_US * CORE_CLK_MHZ;
   localparam int unsigned READY_WIDTH_CYC  = READY_WIDTH_US * CORE_CLK_MHZ;
   localparam int unsigned CNT_W            = 12;
   localparam int unsigned DATA_W           = 10;
   localparam int unsigned ADDR_W           = 12;

   typedef enum logic [1:0] {
      CTI_IDLE  = 2'b00,
      CTI_WAIT  = 2'b01,
      CTI_DONE  = 2'b11
   } cti_xfer_e;
endpackage

/* File: design/cti_sync2.sv */
// Two-flop synchroniser for levels entering the core clock domain.
// Assumes the input may change at any time relative to core_clk.
`timescale 1ns/100ps
module cti_sync2 (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   logic meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         dout   <= 1'b0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

/* File: design/cti_pulse.sv */
// Retriggerable one-shot: holds its output high for a fixed count after a start; a new start reloads the count.
// Assumes start is a one-cycle pulse on core_clk.
`timescale 1ns/100ps
module cti_pulse
   import cti_pkg::*;
#(
   parameter logic [11:0] WIDTH = 12'h001
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic start,
   output logic      busy
);
   logic [11:0] cnt_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 12'h000;
      end else if (start) begin
         cnt_q <= WIDTH;
      end else if (cnt_q != 12'h000) begin
         cnt_q <= cnt_q - 12'h001;
      end
   end

   assign busy = (cnt_q != 12'h000);
endmodule

/* File: design/cti_top.sv */
// Computer telemetry interface: places adapter data words into selected format slots.
// Assumes slot sync, frame sync, address, data and request come from outside the clock domain.
//
// What this block does
// - Slot counter divides sync pulses by thirty
// - Counters recycle to one after 30/10/3
// - Common reset forces all counters to one
// - Frame counter divides slot wraps by ten
// - Shared counter divides slot wraps by three
// - Timing derives common reset and load phase
// - Address synchronised, compared by comparators, detectors
// - Phase and bits 2-6 match slot counter
// - Bits 7-10 zero or frame match
// - Bits 11-12 match shared counter stages
// - Bits 11-12 zero or shared match
// - Gate needs matches, sync and request
// - Out-of-sync counters block any transfer
// - Clear holding word, then load later
// - Load starts data-ready one-shot pulse
`timescale 1ns/100ps
module cti_top
   import cti_pkg::*;
#(
   parameter logic [11:0] CLR_TO_LOAD = CLR_TO_LOAD_CYC[11:0],
   parameter logic [11:0] READY_WIDTH = READY_WIDTH_CYC[11:0]
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              slot_sync,
   input  wire logic              frame_sync,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] data_in,
   input  wire logic              data_request,
   output logic      [DATA_W-1:0] word_holding_card,
   output logic                   data_ready,
   output logic                   in_sync,
   output logic      [4:0]        slot_count,
   output logic      [3:0]        frame_count,
   output logic      [1:0]        shared_count
);
   logic              slot_s;
   logic              frame_s;
   logic              req_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic              slot_prev_q;
   logic              frame_prev_q;
   logic              phase_q;
   logic [4:0]        slot_q;
   logic [3:0]        frame_q;
   logic [1:0]        shared_q;
   logic              in_sync_q;
   logic              slot_wrap;
   logic              slot_step;
   logic              common_rst;
   logic              comp_a;
   logic              comp_b;
   logic              comp_c;
   logic              frame_match_or_ignore;
   logic              shared_match_or_ignore;
   logic              data_entry_gate;
   logic              gate_prev_q;
   logic              fire;
   cti_xfer_e         st_q;
   logic [11:0]       dly_q;
   logic              load_stb;
   logic [DATA_W-1:0] hold_q;

   // Every pin but core_clk and rst crosses two flops before any logic sees it
   cti_sync2 u_sync_slot (
      .core_clk (core_clk),
      .rst      (rst),
      .din      (slot_sync),
      .dout     (slot_s)
   );

   cti_sync2 u_sync_frame (
      .core_clk (core_clk),
      .rst      (rst),
      .din      (frame_sync),
      .dout     (frame_s)
   );

   cti_sync2 u_sync_req (
      .core_clk (core_clk),
      .rst      (rst),
      .din      (data_request),
      .dout     (req_s)
   );

   // Address and data are buses; each line is synchronised, so a skewed change
   // may look torn for a cycle, which the slot-long match window absorbs
   genvar gi;
   generate
      for (gi = 0; gi < ADDR_W; gi++) begin : g_addr
         cti_sync2 u_sync_a (
            .core_clk (core_clk),
            .rst      (rst),
            .din      (addr[gi]),
            .dout     (addr_s[gi])
         );
      end
      for (gi = 0; gi < DATA_W; gi++) begin : g_data
         cti_sync2 u_sync_d (
            .core_clk (core_clk),
            .rst      (rst),
            .din      (data_in[gi]),
            .dout     (data_s[gi])
         );
      end
   endgenerate

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         slot_prev_q  <= 1'b0;
         frame_prev_q <= 1'b0;
      end else begin
         slot_prev_q  <= slot_s;
         frame_prev_q <= frame_s;
      end
   end

   // Rising edge of the restored sync steps the slot counter
   assign slot_step  = slot_s & ~slot_prev_q;
   // Rising edge of the frame sync is the common counter reset
   assign common_rst = frame_s & ~frame_prev_q;
   assign slot_wrap  = slot_step && (slot_q == SLOT_MAX);

   // Phase waveform: toggled at each step, half-rate square of the slot clock
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phase_q <= 1'b0;
      end else if (common_rst) begin
         phase_q <= 1'b0;
      end else if (slot_step) begin
         phase_q <= ~phase_q;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         slot_q <= SLOT_RST_VAL;
      end else if (common_rst) begin
         slot_q <= SLOT_RST_VAL;
      end else if (slot_wrap) begin
         slot_q <= SLOT_RST_VAL;
      end else if (slot_step) begin
         slot_q <= slot_q + 5'h01;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         frame_q <= FRAME_RST_VAL;
      end else if (common_rst) begin
         frame_q <= FRAME_RST_VAL;
      end else if (slot_wrap) begin
         frame_q <= (frame_q == FRAME_MAX) ? FRAME_RST_VAL : frame_q + 4'h1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shared_q <= SHARED_RST_VAL;
      end else if (common_rst) begin
         shared_q <= SHARED_RST_VAL;
      end else if (slot_wrap) begin
         shared_q <= (shared_q == SHARED_MAX) ? SHARED_RST_VAL : shared_q + 2'h1;
      end
   end

   // In sync once a frame sync lands exactly where the slot and frame counters are both at one;
   // a frame sync anywhere else means the counters had drifted
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         in_sync_q <= 1'b0;
      end else if (common_rst) begin
         in_sync_q <= (slot_q == SLOT_RST_VAL) && (frame_q == FRAME_RST_VAL);
      end
   end

   // Address bit n, counted from one, is addr_s[n-1]
   assign comp_a = (addr_s[0] == phase_q) && (addr_s[5:1] == slot_q);
   assign comp_b = (addr_s[9:6] == frame_q);
   assign comp_c = (addr_s[10] == shared_q[0]) && (addr_s[11] == shared_q[1]);
   assign frame_match_or_ignore  = comp_b || (addr_s[9:6] == 4'h0);
   assign shared_match_or_ignore = comp_c || (addr_s[11:10] == 2'h0);
   assign data_entry_gate = comp_a && frame_match_or_ignore && shared_match_or_ignore
                            && in_sync_q && req_s;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gate_prev_q <= 1'b0;
      end else begin
         gate_prev_q <= data_entry_gate;
      end
   end

   // Only the first true cycle of a comparison starts a transfer
   assign fire = data_entry_gate & ~gate_prev_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q  <= CTI_IDLE;
         dly_q <= 12'h000;
      end else begin
         case (st_q)
            CTI_IDLE: begin
               if (fire) begin
                  st_q  <= CTI_WAIT;
                  dly_q <= CLR_TO_LOAD;
               end
            end
            CTI_WAIT: begin
               if (dly_q <= 12'h001) begin
                  st_q <= CTI_DONE;
               end else begin
                  dly_q <= dly_q - 12'h001;
               end
            end
            CTI_DONE: begin
               st_q <= CTI_IDLE;
            end
            default: begin
               st_q <= CTI_IDLE;
            end
         endcase
      end
   end

   assign load_stb = (st_q == CTI_DONE);

   // Clear on the start, load at the end of the delay; data must be steady by then
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hold_q <= {DATA_W{1'b0}};
      end else if (st_q == CTI_IDLE && fire) begin
         hold_q <= {DATA_W{1'b0}};
      end else if (load_stb) begin
         hold_q <= data_s;
      end
   end

   cti_pulse #(
      .WIDTH (READY_WIDTH)
   ) u_ready (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (load_stb),
      .busy     (data_ready)
   );

   assign word_holding_card = hold_q;
   assign in_sync           = in_sync_q;
   assign slot_count        = slot_q;
   assign frame_count       = frame_q;
   assign shared_count      = shared_q;
endmodule

/* File: dv/cti_top_chk.sv */
// Checker for cti_top: counter steps, gated transfer and ready pulse.
// Assumes it is bound to cti_top and sees only its ports.
`timescale 1ns/100ps
module cti_top_chk
   import cti_pkg::*;
#(
   parameter logic [11:0] CLR_TO_LOAD = 12'h004,
   parameter logic [11:0] READY_WIDTH = 12'h003
) (
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              slot_sync,
   input wire logic              frame_sync,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic              data_request,
   input wire logic [DATA_W-1:0] word_holding_card,
   input wire logic              data_ready,
   input wire logic              in_sync,
   input wire logic [4:0]        slot_count,
   input wire logic [3:0]        frame_count,
   input wire logic [1:0]        shared_count
);
   logic [11:0] len_q;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         len_q <= 12'h000;
      end else begin
         len_q <= data_ready ? len_q + 12'h001 : 12'h000;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_rng;
      slot_count inside {[SLOT_RST_VAL:SLOT_MAX]} && frame_count inside {[FRAME_RST_VAL:FRAME_MAX]}
         && shared_count inside {[SHARED_RST_VAL:SHARED_MAX]};
   endproperty
   a_rng: assert property (p_rng) else $error("counter out of range");
   property p_step;
      $changed(slot_count) |-> slot_count == $past(slot_count) + 5'h01 || slot_count == 5'h01;
   endproperty
   a_step: assert property (p_step) else $error("slot counter skipped");
   property p_fstep;
      $changed(frame_count) && frame_count != 4'h1 |-> $past(slot_count) == SLOT_MAX
         && slot_count == 5'h01 && frame_count == $past(frame_count) + 4'h1;
   endproperty
   a_fstep: assert property (p_fstep) else $error("frame step not on slot wrap");
   property p_shared;
      $changed(shared_count) |-> slot_count == SLOT_RST_VAL;
   endproperty
   a_shared: assert property (p_shared) else $error("shared step not on slot wrap");
   property p_rlen;
      $fell(data_ready) |-> len_q == READY_WIDTH;
   endproperty
   a_rlen: assert property (p_rlen) else $error("ready pulse width wrong");
   property p_rreq;
      $rose(data_ready) |-> data_request && in_sync;
   endproperty
   a_rreq: assert property (p_rreq) else $error("ready without request or sync");
   property p_raddr;
      $rose(data_ready) |-> addr[5:1] == slot_count && (addr[9:6] == 4'h0
         || addr[9:6] == frame_count) && (addr[11:10] == 2'h0 || addr[11:10] == shared_count);
   endproperty
   a_raddr: assert property (p_raddr) else $error("transfer in wrong slot");
   property p_load;
      $changed(word_holding_card) && word_holding_card != 10'h000 |-> $rose(data_ready)
         && word_holding_card == data_in;
   endproperty
   a_load: assert property (p_load) else $error("load not followed by ready");
   property p_sync;
      $rose(in_sync) |-> slot_count == 5'h01 && frame_count == 4'h1;
   endproperty
   a_sync: assert property (p_sync) else $error("sync taken off frame start");
   c_ready: cover property ($rose(data_ready));
   c_sync: cover property ($rose(in_sync));
   c_fwrap: cover property (frame_count == FRAME_MAX ##1 frame_count == 4'h1);
endmodule
bind cti_top cti_top_chk #(.CLR_TO_LOAD(CLR_TO_LOAD), .READY_WIDTH(READY_WIDTH)) u_chk (
   .core_clk(core_clk), .rst(rst), .slot_sync(slot_sync), .frame_sync(frame_sync),
   .addr(addr), .data_in(data_in), .data_request(data_request), .data_ready(data_ready),
   .word_holding_card(word_holding_card), .in_sync(in_sync), .slot_count(slot_count),
   .frame_count(frame_count), .shared_count(shared_count));

/* File: dv/cti_enc_model.sv */
// Encoder timing model: slot sync every 160 ns, frame sync every 300 slots.
// Assumes run starts it; misfs asks for one frame sync out of place.
`timescale 1ns/100ps
module cti_enc_model (
   input  wire logic run,
   input  wire logic misfs,
   output logic      slot_sync,
   output logic      frame_sync
);
   int k;
   initial begin
      slot_sync = 1'b0;
      frame_sync = 1'b0;
      k = 0;
      forever begin
         wait (run);
         // Frame sync sits in the low half so it never races a slot edge
         frame_sync = (k % 300 == 0) || misfs;
         #40;
         frame_sync = 1'b0;
         #40;
         slot_sync = 1'b1;
         #80;
         slot_sync = 1'b0;
         k++;
      end
   end
endmodule

/* File: dv/tb.sv */
// Testbench for cti_top: counters, gated transfers and loss of sync.
// Assumes cti_enc_model drives the sync pins and the checker is bound.
`timescale 1ns/100ps
module tb;
   import cti_pkg::*;
   logic              core_clk, rst, run, misfs, slot_sync, frame_sync;
   logic              data_request, data_ready, in_sync;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] data_in, word_holding_card;
   logic [4:0]        slot_count;
   logic [3:0]        frame_count;
   logic [1:0]        shared_count;
   int                n_mismatch = 0, num_checks = 0, cyc = 0, n = 0;
   cti_top #(.CLR_TO_LOAD(12'h004), .READY_WIDTH(12'h003)) uut (
      .core_clk(core_clk), .rst(rst), .slot_sync(slot_sync), .frame_sync(frame_sync),
      .addr(addr), .data_in(data_in), .data_request(data_request), .data_ready(data_ready),
      .word_holding_card(word_holding_card), .in_sync(in_sync), .slot_count(slot_count),
      .frame_count(frame_count), .shared_count(shared_count));
   cti_enc_model enc (.run(run), .misfs(misfs), .slot_sync(slot_sync), .frame_sync(frame_sync));
   always @(posedge frame_sync) n = 0;
   always @(posedge slot_sync) n = n + 1;
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   // Any ready pulse in the window is a refused transfer gone through
   task automatic quiet(input int c);
      int hits;
      hits = 0;
      @(posedge core_clk);
      data_request <= 1'b1;
      repeat (c) begin
         @(posedge core_clk);
         #1;
         if (data_ready !== 1'b0) hits++;
      end
      chk(12'(hits), 12'h000);
      @(posedge core_clk);
      data_request <= 1'b0;
   endtask
   task automatic t_counts;
      run <= 1'b1;
      repeat (310) begin
         @(posedge slot_sync);
         repeat (6) @(posedge core_clk);
         #1;
         chk(12'(slot_count), 12'(n % 30 + 1));
         chk(12'(frame_count), 12'(n / 30 % 10 + 1));
         chk(12'(shared_count), 12'(n / 30 % 3 + 1));
      end
      chk(12'(in_sync), 12'h001);
   endtask
   task automatic t_xfer(input logic [4:0] s, input logic [3:0] fr, input logic [1:0] sh,
                         input logic [9:0] d);
      int  k;
      logic clr;
      clr = 1'b0;
      // Request outside the target slot so the gate opens at the slot start
      while (slot_count === s) @(posedge core_clk) #1;
      @(posedge core_clk);
      addr <= {sh, fr, s, ~s[0]};
      data_in <= d;
      data_request <= 1'b1;
      for (k = 0; k < 6000 && data_ready !== 1'b1; k++) begin
         @(posedge core_clk);
         #1;
         if (word_holding_card === 10'h000) clr = 1'b1;
      end
      chk(12'(slot_count), 12'(s));
      if (fr != 4'h0) chk(12'(frame_count), 12'(fr));
      if (sh != 2'h0) chk(12'(shared_count), 12'(sh));
      chk(12'(word_holding_card), 12'(d));
      chk(12'(clr), 12'h001);
      for (k = 0; data_ready === 1'b1 && k < 20; k++) @(posedge core_clk) #1;
      chk(12'(k), 12'h003);
      @(posedge core_clk);
      data_request <= 1'b0;
   endtask
   task automatic t_lost;
      while (slot_count !== 5'h05) @(posedge core_clk) #1;
      misfs <= 1'b1;
      @(posedge frame_sync);
      misfs <= 1'b0;
      repeat (6) @(posedge core_clk);
      #1;
      chk(12'(in_sync), 12'h000);
      chk({1'b0, slot_count, frame_count, shared_count}, 12'h045);
      @(posedge core_clk);
      addr <= 12'h005;
      quiet(200);
   endtask
   initial begin
      rst = 1'b1;
      run = 1'b0;
      misfs = 1'b0;
      addr = 12'h002;
      data_in = 10'h000;
      data_request = 1'b0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      // Counters all at one, nothing held or signalled
      chk({1'b0, slot_count, frame_count, shared_count}, 12'h045);
      chk({in_sync, data_ready, word_holding_card}, 12'h000);
      quiet(40);
      t_counts();
      t_xfer(5'h01, 4'h0, 2'h0, 10'h2a5);
      t_xfer(5'h1e, 4'h9, 2'h3, 10'h15a);
      t_xfer(5'h10, 4'ha, 2'h0, 10'h3c3);
      t_xfer(5'h07, 4'h0, 2'h2, 10'h0f1);
      t_lost();
      give_verdict();
   end
endmodule
